// ---- verilog/pie_consts.svh ----
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH

`define PIE_OFS_EN_ONE    4'h0
`define PIE_OFS_EN_TWO    4'h1
`define PIE_OFS_EN_THREE  4'h2
`define PIE_OFS_CORE      4'h3
`define PIE_OFS_FLAG_ONE  4'h4
`define PIE_OFS_FLAG_TWO  4'h5
`define PIE_OFS_FLAG_THR  4'h6
`define PIE_OFS_IRQ_STAT  4'h7
`define PIE_OFS_IRQ_MASK  4'h8
`define PIE_MASK_ONE      8'hff
`define PIE_MASK_TWO      8'hf9
`define PIE_MASK_THREE    8'h3a
`define PIE_MASK_CORE     8'hc0
`define PIE_BIT_GLOBAL    7
`define PIE_BIT_GROUP     6
`define PIE_RST_BYTE      8'h00
`define PIE_RST_WORD      32'h0000_0000
`define PIE_ST_BITS       2
`define PIE_ST_REQ        0
`define PIE_ST_ENTRY      1

`endif

// ---- verilog/pie_pkg.sv ----
package pie_pkg;
  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
  } pie_bank_s;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pie_avm_req_s;

  typedef enum logic [1:0] {
    PIE_IDLE,
    PIE_ANSWER
  } pie_bus_e;
endpackage : pie_pkg

// ---- verilog/pie_flag_bank.sv ----
`timescale 1ns/1ps
`include "pie_consts.svh"

module pie_flag_bank #(
  parameter int          W    = 8,
  parameter logic [7:0]  IMPL = 8'hff
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] event_in,
  input  wire logic [W-1:0] clear_in,
  output logic      [W-1:0] flag_out
);
  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;

  // flag independent of enables.
  // A new event wins over a clear in the same cycle.
  always_comb begin
    flag_next = ((flag_reg & ~clear_in) | event_in) & IMPL[W-1:0];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

  property p_flag_set;
    @(posedge CLK) disable iff (!RST_N)
      (event_in[0] && IMPL[0]) |=> flag_out[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event lost in flag bank");
endmodule : pie_flag_bank

// ---- verilog/pie_enable_bank.sv ----
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pie_consts.svh"

// Summary of operation
// - Group enable gates all peripheral requests.
// - Bank one bits 7,6: gate, converter.
// - Bank one bits 5,4: serial receive, transmit.
// - Bank one bits 3,2: sync port, capcomp one.
// - Bank one bits 1,0: timer2 match, timer1 overflow.
// - Bank two bits 7,6,5: oscfail, comparators.
// - Bank two bits 4,3,0: eeprom, collision, capcomp.
// - Unimplemented bits read zero, ignore writes.
// - Bank three bits 5,4: capcomp four, three.
// - Bank three bits 3,1: timer6, timer4 match.
// - Enable bits read/write, reset to zero.
// - Flags set regardless of any enable.
// - Global enable gates CORE_IRQ_REQ; IRQ status bit 0 (any enabled flag) is not gated.

module pie_enable_bank (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic [3:0]          AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  input  wire logic [3:0]          AVS_BYTEENABLE,
  output logic      [31:0]         AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  input  wire pie_pkg::pie_bank_s  PERIPH_EVENT,
  input  wire logic                CORE_OTHER_REQ,
  input  wire logic                CORE_ENTRY_ACK,
  output logic                     PERIPH_REQ,
  output logic                     CORE_IRQ_REQ,
  output pie_pkg::pie_bank_s       FLAGS,
  output logic                     IRQ
);
  import pie_pkg::*;

  pie_avm_req_s req;
  pie_bus_e     bus_reg;
  pie_bus_e     bus_next;
  pie_bank_s    en_reg;
  pie_bank_s    en_next;
  logic [7:0]   core_reg;
  logic [7:0]   core_next;
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;
  logic [1:0]   stat_reg;
  logic [1:0]   stat_next;
  logic [1:0]   mask_reg;
  logic [1:0]   mask_next;
  pie_bank_s    flag_clr;
  pie_bank_s    flag_q;
  logic         periph_any;
  logic         core_req;
  logic         do_wr;
  logic         do_rd;
  logic         rd_start;
  logic         core_req_d_reg;
  logic [1:0]   stat_set;

  assign req = '{address: AVS_ADDRESS, read: AVS_READ, write: AVS_WRITE,
                 writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};
  assign do_wr = (bus_reg == PIE_ANSWER) && req.write && req.byteenable[0];
  assign do_rd = (bus_reg == PIE_ANSWER) && req.read;
  assign rd_start = (bus_reg == PIE_IDLE) && req.read;

  pie_flag_bank #(.W(8), .IMPL(`PIE_MASK_ONE)) u_flag_one (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .event_in (PERIPH_EVENT.one),
    .clear_in (flag_clr.one),
    .flag_out (flag_q.one)
  );
  pie_flag_bank #(.W(8), .IMPL(`PIE_MASK_TWO)) u_flag_two (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .event_in (PERIPH_EVENT.two),
    .clear_in (flag_clr.two),
    .flag_out (flag_q.two)
  );
  pie_flag_bank #(.W(8), .IMPL(`PIE_MASK_THREE)) u_flag_three (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .event_in (PERIPH_EVENT.three),
    .clear_in (flag_clr.three),
    .flag_out (flag_q.three)
  );

  // Writing one to a flag position clears it.
  always_comb begin
    flag_clr = '0;
    if (do_wr && req.address == `PIE_OFS_FLAG_ONE) begin
      flag_clr.one = req.writedata[7:0];
    end
    if (do_wr && req.address == `PIE_OFS_FLAG_TWO) begin
      flag_clr.two = req.writedata[7:0];
    end
    if (do_wr && req.address == `PIE_OFS_FLAG_THR) begin
      flag_clr.three = req.writedata[7:0];
    end
  end

  assign periph_any = |(flag_q & en_reg);
  assign core_req = core_reg[`PIE_BIT_GLOBAL]
                    && ((core_reg[`PIE_BIT_GROUP] && periph_any) || CORE_OTHER_REQ);
  assign PERIPH_REQ   = core_reg[`PIE_BIT_GROUP] && periph_any;
  assign CORE_IRQ_REQ = core_req;
  assign FLAGS        = flag_q;

  // One wait state per access: waitrequest drops in the answer cycle.
  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      PIE_IDLE: begin
        if (req.read || req.write) begin
          bus_next = PIE_ANSWER;
        end
      end
      PIE_ANSWER: begin
        bus_next = PIE_IDLE;
      end
      default: begin
        bus_next = PIE_IDLE;
      end
    endcase
  end
  assign AVS_WAITREQUEST = (req.read || req.write) && (bus_reg != PIE_ANSWER);

  assign stat_set = {core_req && !core_req_d_reg, periph_any};

  always_comb begin
    en_next    = en_reg;
    core_next  = core_reg;
    mask_next  = mask_reg;
    rdata_next = rdata_reg;
    stat_next  = stat_reg;
    if (do_wr) begin
      case (req.address)
        `PIE_OFS_EN_ONE: en_next.one = req.writedata[7:0] & `PIE_MASK_ONE;
        `PIE_OFS_EN_TWO: en_next.two = req.writedata[7:0] & `PIE_MASK_TWO;
        `PIE_OFS_EN_THREE: en_next.three = req.writedata[7:0] & `PIE_MASK_THREE;
        `PIE_OFS_CORE: core_next = req.writedata[7:0] & `PIE_MASK_CORE;
        `PIE_OFS_IRQ_MASK: mask_next = req.writedata[1:0];
        default: begin
        end
      endcase
    end
    // Read data are loaded in the wait cycle so they stand when waitrequest drops.
    // Status shows the bits that are being set now, as the clear follows one edge later.
    if (rd_start) begin
      case (req.address)
        `PIE_OFS_EN_ONE:   rdata_next = {24'h000000, en_reg.one};
        `PIE_OFS_EN_TWO:   rdata_next = {24'h000000, en_reg.two};
        `PIE_OFS_EN_THREE: rdata_next = {24'h000000, en_reg.three};
        `PIE_OFS_CORE:     rdata_next = {24'h000000, core_reg};
        `PIE_OFS_FLAG_ONE: rdata_next = {24'h000000, flag_q.one};
        `PIE_OFS_FLAG_TWO: rdata_next = {24'h000000, flag_q.two};
        `PIE_OFS_FLAG_THR: rdata_next = {24'h000000, flag_q.three};
        `PIE_OFS_IRQ_STAT: rdata_next = {30'h0, stat_reg | stat_set};
        `PIE_OFS_IRQ_MASK: rdata_next = {30'h0, mask_reg};
        default:           rdata_next = `PIE_RST_WORD;
      endcase
    end
    // Reading status clears it, but a new event in that cycle survives.
    if (do_rd && req.address == `PIE_OFS_IRQ_STAT) begin
      stat_next = stat_set;
    end else begin
      stat_next = stat_reg | stat_set;
    end
    // Core entry clears global enable, as interrupt entry does.
    if (CORE_ENTRY_ACK) begin
      core_next[`PIE_BIT_GLOBAL] = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_reg        <= PIE_IDLE;
      en_reg         <= '0;
      core_reg       <= `PIE_RST_BYTE;
      mask_reg       <= 2'h0;
      stat_reg       <= 2'h0;
      rdata_reg      <= `PIE_RST_WORD;
      core_req_d_reg <= 1'b0;
    end else begin
      bus_reg        <= bus_next;
      en_reg         <= en_next;
      core_reg       <= core_next;
      mask_reg       <= mask_next;
      stat_reg       <= stat_next;
      rdata_reg      <= rdata_next;
      core_req_d_reg <= core_req;
    end
  end

  assign AVS_READDATA = rdata_reg;
  assign IRQ = |(stat_reg & mask_reg);

  property p_group_gate;
    @(posedge CLK) disable iff (!RST_N)
      !core_reg[`PIE_BIT_GROUP] |-> !PERIPH_REQ;
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("request without group");

  property p_global_gate;
    @(posedge CLK) disable iff (!RST_N)
      !core_reg[`PIE_BIT_GLOBAL] |-> !CORE_IRQ_REQ;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("request without global");

  property p_en_one_wr;
    @(posedge CLK) disable iff (!RST_N)
      (do_wr && req.address == `PIE_OFS_EN_ONE)
        |=> (en_reg.one == $past(req.writedata[7:0]));
  endproperty
  a_en_one_wr: assert property (p_en_one_wr) else $error("bank one write lost");

  property p_unimpl_zero;
    @(posedge CLK) disable iff (!RST_N)
      (en_reg.two[2:1] == 2'h0) && (en_reg.three[7:6] == 2'h0)
        && !en_reg.three[2] && !en_reg.three[0];
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_combined;
    @(posedge CLK) disable iff (!RST_N)
      (core_reg[`PIE_BIT_GROUP] && (flag_q.two[7] && en_reg.two[7])) |-> PERIPH_REQ;
  endproperty
  a_combined: assert property (p_combined) else $error("combined request missing");

  property p_flag_indep;
    @(posedge CLK) disable iff (!RST_N)
      (PERIPH_EVENT.three[5] && en_reg.three == 8'h00) |=> flag_q.three[5];
  endproperty
  a_flag_indep: assert property (p_flag_indep) else $error("flag gated by enable");

  property p_rd_en_two;
    @(posedge CLK) disable iff (!RST_N)
      (do_rd && req.address == `PIE_OFS_EN_TWO) |-> (AVS_READDATA[7:0] == en_reg.two);
  endproperty
  a_rd_en_two: assert property (p_rd_en_two) else $error("bank two readback wrong");

  property p_wait_one;
    @(posedge CLK) disable iff (!RST_N)
      ($rose(AVS_READ) && bus_reg == PIE_IDLE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");

  property p_rd_en_one;
    @(posedge CLK) disable iff (!RST_N)
      (do_rd && req.address == `PIE_OFS_EN_ONE) |-> (AVS_READDATA[7:0] == en_reg.one);
  endproperty
  a_rd_en_one: assert property (p_rd_en_one) else $error("bank one readback wrong");

  property p_bank_one_req;
    @(posedge CLK) disable iff (!RST_N)
      (core_reg[`PIE_BIT_GROUP] && ((flag_q.one & en_reg.one) != 8'h00)) |-> PERIPH_REQ;
  endproperty
  a_bank_one_req: assert property (p_bank_one_req) else $error("bank one source silent");

  property p_bank_two_req;
    @(posedge CLK) disable iff (!RST_N)
      (core_reg[`PIE_BIT_GROUP] && ((flag_q.two & en_reg.two) != 8'h00)) |-> PERIPH_REQ;
  endproperty
  a_bank_two_req: assert property (p_bank_two_req) else $error("bank two source silent");

  property p_bank_three_req;
    @(posedge CLK) disable iff (!RST_N)
      (core_reg[`PIE_BIT_GROUP] && ((flag_q.three & en_reg.three) != 8'h00)) |-> PERIPH_REQ;
  endproperty
  a_bank_three_req: assert property (p_bank_three_req) else $error("bank three source silent");

  property p_no_source;
    @(posedge CLK) disable iff (!RST_N)
      ((flag_q & en_reg) == 24'h000000) |-> !PERIPH_REQ;
  endproperty
  a_no_source: assert property (p_no_source) else $error("request with no source");

  property p_entry_clear;
    @(posedge CLK) disable iff (!RST_N)
      CORE_ENTRY_ACK |=> !core_reg[`PIE_BIT_GLOBAL];
  endproperty
  a_entry_clear: assert property (p_entry_clear) else $error("global enable kept on entry");

  property p_be_ignored;
    @(posedge CLK) disable iff (!RST_N)
      ((bus_reg == PIE_ANSWER) && req.write && !req.byteenable[0]) |=> $stable(en_reg);
  endproperty
  a_be_ignored: assert property (p_be_ignored) else $error("write without low lane landed");

  property p_stat_clear;
    @(posedge CLK) disable iff (!RST_N)
      (do_rd && (req.address == `PIE_OFS_IRQ_STAT) && (stat_set == 2'h0))
        |=> (stat_reg == 2'h0);
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status kept after read");

  c_periph: cover property (@(posedge CLK) disable iff (!RST_N) PERIPH_REQ);
  c_core:   cover property (@(posedge CLK) disable iff (!RST_N) CORE_IRQ_REQ);
  c_irq:    cover property (@(posedge CLK) disable iff (!RST_N) IRQ);
endmodule : pie_enable_bank

// ---- verif/pie_src_core.sv ----
`timescale 1ns/1ps

module pie_src_core (
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic [23:0]   FIRE,
  input  wire logic [3:0]    ACK_DELAY,
  input  wire logic          CORE_IRQ_REQ,
  output pie_pkg::pie_bank_s PERIPH_EVENT,
  output logic               CORE_ENTRY_ACK
);
  import pie_pkg::*;
  logic [3:0] wait_reg;

  // Events are one-cycle pulses; the core acknowledges after ACK_DELAY cycles, never at zero.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PERIPH_EVENT   <= '0;
      CORE_ENTRY_ACK <= 1'b0;
      wait_reg       <= 4'h0;
    end else begin
      PERIPH_EVENT   <= FIRE;
      CORE_ENTRY_ACK <= 1'b0;
      if (!CORE_IRQ_REQ || ACK_DELAY == 4'h0 || CORE_ENTRY_ACK) begin
        wait_reg <= 4'h0;
      end else if (wait_reg + 4'h1 >= ACK_DELAY) begin
        CORE_ENTRY_ACK <= 1'b1;
        wait_reg       <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : pie_src_core

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "pie_consts.svh"

module tb;
  import pie_pkg::*;
  localparam logic [23:0] IMPL = {`PIE_MASK_ONE, `PIE_MASK_TWO, `PIE_MASK_THREE};
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'h0;
  logic        CORE_OTHER_REQ = 1'b0;
  logic [23:0] FIRE = 24'h0;
  logic [3:0]  ACK_DELAY = 4'h0;
  logic [31:0] AVS_READDATA, q;
  logic        AVS_WAITREQUEST, PERIPH_REQ, CORE_IRQ_REQ, CORE_ENTRY_ACK, IRQ;
  pie_bank_s   PERIPH_EVENT, FLAGS;
  logic [23:0] m_en = 24'h0, m_flag = 24'h0, e;
  logic [7:0]  m_core = 8'h00;
  int          failures = 0, cmp_count = 0, b, k;

  always #50 CLK = ~CLK;

  pie_enable_bank dut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PERIPH_EVENT(PERIPH_EVENT),
    .CORE_OTHER_REQ(CORE_OTHER_REQ), .CORE_ENTRY_ACK(CORE_ENTRY_ACK),
    .PERIPH_REQ(PERIPH_REQ), .CORE_IRQ_REQ(CORE_IRQ_REQ), .FLAGS(FLAGS), .IRQ(IRQ));
  pie_src_core src (.CLK(CLK), .RST_N(RST_N), .FIRE(FIRE), .ACK_DELAY(ACK_DELAY),
    .CORE_IRQ_REQ(CORE_IRQ_REQ), .PERIPH_EVENT(PERIPH_EVENT), .CORE_ENTRY_ACK(CORE_ENTRY_ACK));

  // Core entry drops the global enable in the model too.
  always @(posedge CLK) if (CORE_ENTRY_ACK === 1'b1) m_core[`PIE_BIT_GLOBAL] = 1'b0;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t expected %h got %h", $time, exp, got);
    end
  endtask : cmp

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    AVS_ADDRESS    <= a;
    AVS_WRITE      <= w;
    AVS_READ       <= !w;
    AVS_WRITEDATA  <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge CLK);
    end
    q = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK);
  endtask : bus

  task automatic chk_outs();
    logic p;
    p = m_core[`PIE_BIT_GROUP] & |(m_flag & m_en);
    cmp({31'h0, p}, {31'h0, PERIPH_REQ});
    cmp({31'h0, m_core[7] & (p | CORE_OTHER_REQ)}, {31'h0, CORE_IRQ_REQ});
    cmp({8'h0, m_flag}, {8'h0, FLAGS});
  endtask : chk_outs

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
    if (a < 4'h3) m_en[23-8*a -: 8] = d & IMPL[23-8*a -: 8];
    else if (a == 4'h3) m_core = d & `PIE_MASK_CORE;
    else if (a < 4'h7) m_flag[23-8*(a-4) -: 8] &= ~d;
    chk_outs();
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00, 4'hf);
    cmp({24'h0, x}, q);
  endtask : rd

  task automatic fire(input logic [23:0] v);
    FIRE <= v;
    @(posedge CLK);
    FIRE <= 24'h0;
    repeat (2) @(posedge CLK);
    m_flag |= v;
    chk_outs();
  endtask : fire

  task automatic clear_flags();
    for (int i = 4; i < 7; i++) wr(i[3:0], 8'hff);
  endtask : clear_flags

  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(92021));
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    for (k = 0; k < 16; k++) rd(k[3:0], 8'h00);
    $display("test reset values done");
    for (k = 0; k < 3; k++) begin
      b = $urandom;
      wr(k[3:0], 8'hff);
      rd(k[3:0], m_en[23-8*k -: 8]);
      wr(k[3:0], b[7:0]);
      bus(1'b1, k[3:0], ~b[7:0], 4'he);
      rd(k[3:0], m_en[23-8*k -: 8]);
    end
    wr(4'hb, 8'hff);
    rd(4'hb, 8'h00);
    $display("test register access done");
    wr(4'h3, 8'h40);
    for (b = 0; b < 24; b++) if (IMPL[b]) begin
      e = 24'h1 << b;
      clear_flags();
      for (k = 0; k < 3; k++) wr(k[3:0], e[23-8*k -: 8]);
      fire(IMPL & ~e);
      fire(e);
      wr(4'h3, 8'h00);
      wr(4'h3, 8'h40);
    end
    for (k = 0; k < 20; k++) begin
      clear_flags();
      b = $urandom;
      wr(4'(k % 3), b[7:0]);
      fire(b[31:8] & IMPL);
    end
    $display("test source gating done");
    clear_flags();
    wr(4'h0, 8'h80);
    fire(e);
    for (k = 4; k > 0; k -= 3) begin
      ACK_DELAY <= k[3:0];
      wr(4'h3, 8'hc0);
      repeat (8) @(posedge CLK);
      chk_outs();
      rd(4'h3, m_core);
    end
    ACK_DELAY <= 4'h0;
    CORE_OTHER_REQ <= 1'b1;
    @(posedge CLK);
    chk_outs();
    CORE_OTHER_REQ <= 1'b0;
    $display("test global enable done");
    wr(4'h3, 8'h40);
    wr(4'h8, 8'h00);
    fire(e);
    repeat (2) @(posedge CLK);
    cmp(32'h0, {31'h0, IRQ});
    wr(4'h8, 8'h01);
    repeat (2) @(posedge CLK);
    cmp(32'h1, {31'h0, IRQ});
    clear_flags();
    bus(1'b0, 4'h7, 8'h00, 4'hf);
    cmp(32'h1, {31'h0, q[0]});
    bus(1'b0, 4'h7, 8'h00, 4'hf);
    cmp(32'h0, {31'h0, q[0]});
    cmp(32'h0, {31'h0, IRQ});
    $display("test interrupt status done");
    tally_and_finish();
  end
endmodule : tb
